// ### rtl/dpl_parser.sv
`timescale 1ns/10ps
module dpl_parser (
  input  wire logic                   i_ref_clk,   // 250 MHz core clock
  input  wire logic                   i_srst,      // Sync reset, high
  input  wire logic                   i_blk_start, // Header parsed, body follows
  input  wire dpl_pkg::dpl_kind_t     i_blk_kind,  // Kind of block that follows
  input  wire logic [15:0]            i_word_cnt,  // Words in block body
  input  wire logic [15:0]            i_hdr_sum,   // Sum of header bytes
  input  wire logic                   i_byte_vld,  // Image byte strobe
  input  wire logic [7:0]             i_byte,      // Image byte
  output logic                        o_busy,      // Block in progress
  output logic                        o_word_vld,  // Program word pulse
  output logic [53:0]                 o_word,      // Program word
  output logic [15:0]                 o_word_ofs,  // Byte offset of word start
  output logic                        o_blk_done,  // Block checked pulse
  output logic                        o_blk_fail,  // Block failed, with done
  output logic                        o_term_done, // Image ended, level
  output logic                        o_term_err   // Bad termination block
);
  import dpl_pkg::*;

  dpl_state_t          state;
  dpl_kind_t           kind;
  logic [2:0]          biw;
  logic [CNT_W-1:0]    words_left;
  logic [2:0]          pad_left;
  logic [4:0]          term_idx;
  logic [OFS_W-1:0]    ofs;
  logic [OFS_W-1:0]    wstart;
  logic [SUM_W-1:0]    sum;
  logic [7:0]          csum_hi;
  logic                pad_bad;
  logic                term_bad;
  logic                take;
  logic                take_prog;
  logic                asm_done;
  logic [55:0]         asm_word;
  logic [7:0]          first_byte;

  function automatic logic [2:0] word_bytes(input dpl_kind_t k);
    word_bytes = (k == KIND_PROG) ? PROG_WORD_BYTES : DATA_WORD_BYTES;
  endfunction

  function automatic logic [2:0] pad_bytes(input dpl_kind_t k);
    pad_bytes = (k == KIND_PROG) ? PROG_PAD_BYTES : DATA_PAD_BYTES;
  endfunction

  assign take      = i_byte_vld && (state != ST_IDLE) && (state != ST_STOP);
  assign take_prog = take && (state == ST_WORDS) && (kind == KIND_PROG);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (i_blk_start && i_blk_kind == KIND_TERM) begin
            state <= ST_TERM;
          end else if (i_blk_start && i_blk_kind != KIND_NONE) begin
            state <= (i_word_cnt == '0) ? ST_PAD : ST_WORDS;
          end
        end
        ST_WORDS: begin
          if (take && biw == word_bytes(kind) - 3'h1 && words_left == 16'h0001) begin
            state <= ST_PAD;
          end
        end
        ST_PAD: begin
          if (take && pad_left == 3'h1) begin
            state <= ST_CSUM_HI;
          end
        end
        ST_CSUM_HI: begin
          if (take) begin
            state <= ST_CSUM_LO;
          end
        end
        ST_CSUM_LO: begin
          if (take) begin
            state <= ST_IDLE;
          end
        end
        ST_TERM: begin
          if (take && term_idx == TERM_LAST_IDX) begin
            state <= ST_STOP;
          end
        end
        ST_STOP: state <= ST_STOP;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Body counters and offsets
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      kind       <= KIND_NONE;
      biw        <= 3'h0;
      words_left <= '0;
      pad_left   <= 3'h0;
      ofs        <= '0;
      wstart     <= '0;
    end else if (state == ST_IDLE && i_blk_start) begin
      kind       <= i_blk_kind;
      biw        <= 3'h0;
      words_left <= i_word_cnt;
      pad_left   <= pad_bytes(i_blk_kind);
      ofs        <= HDR_BYTES;
    end else if (take) begin
      ofs <= ofs + 16'h0001;
      if (state == ST_WORDS) begin
        if (biw == 3'h0) begin
          wstart <= ofs;
        end
        if (biw == word_bytes(kind) - 3'h1) begin
          biw        <= 3'h0;
          words_left <= words_left - 16'h0001;
        end else begin
          biw <= biw + 3'h1;
        end
      end
      if (state == ST_PAD) begin
        pad_left <= pad_left - 3'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Running sum and trailer check
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      sum     <= '0;
      csum_hi <= 8'h00;
      pad_bad <= 1'b0;
    end else if (state == ST_IDLE && i_blk_start) begin
      sum     <= i_hdr_sum;
      pad_bad <= 1'b0;
    end else if (take && (state == ST_WORDS || state == ST_PAD)) begin
      sum <= sum + {8'h00, i_byte};
      if (state == ST_PAD && i_byte != ZERO_BYTE) begin
        pad_bad <= 1'b1;
      end
    end else if (take && state == ST_CSUM_HI) begin
      csum_hi <= i_byte;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_blk_done <= 1'b0;
      o_blk_fail <= 1'b0;
    end else if (take && state == ST_CSUM_LO) begin
      o_blk_done <= 1'b1;
      o_blk_fail <= ({csum_hi, i_byte} != sum) || pad_bad;
    end else begin
      o_blk_done <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Program word output
  // ---------------------------------------------------------------
  dpl_word_asm #(
    .NBYTES (PROG_ASM_W / BYTE_W)
  ) u_asm (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_clr     (state == ST_IDLE),
    .i_load    (take_prog),
    .i_byte    (i_byte),
    .o_word    (asm_word),
    .o_done    (asm_done)
  );

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_word_vld <= 1'b0;
      o_word     <= '0;
      o_word_ofs <= '0;
    end else begin
      o_word_vld <= asm_done;
      if (asm_done) begin
        o_word     <= asm_word[PROG_VALID_W-1:0];
        o_word_ofs <= wstart;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      first_byte <= 8'h00;
    end else if (take_prog && biw == 3'h0) begin
      first_byte <= i_byte;
    end
  end

  // ---------------------------------------------------------------
  // Termination block
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      term_idx <= 5'h00;
      term_bad <= 1'b0;
    end else if (state == ST_IDLE) begin
      term_idx <= 5'h00;
      term_bad <= 1'b0;
    end else if (take && state == ST_TERM) begin
      term_idx <= term_idx + 5'h01;
      if (term_idx == TERM_ID_IDX) begin
        if (i_byte != TERM_ID_BYTE) begin
          term_bad <= 1'b1;
        end
      end else if (i_byte != ZERO_BYTE) begin
        term_bad <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_term_done <= 1'b0;
      o_term_err  <= 1'b0;
      o_busy      <= 1'b0;
    end else begin
      o_busy <= (state != ST_IDLE && state != ST_STOP)
                || (state == ST_IDLE && i_blk_start && i_blk_kind != KIND_NONE);
      if (take && state == ST_TERM && term_idx == TERM_LAST_IDX) begin
        o_term_done <= 1'b1;
        o_term_err  <= term_bad || (i_byte != ZERO_BYTE);
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_last_pad;
    state == ST_PAD && take && pad_left == 3'h1;
  endsequence

  sequence s_enter_csum;
    state == ST_CSUM_HI;
  endsequence

  a_pad_to_csum: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    s_last_pad |=> s_enter_csum)
    else $error("trailer pad did not end at checksum");

  a_hdr_offset: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state == ST_IDLE && i_blk_start && i_blk_kind != KIND_NONE) |=> ofs == 16'h000c)
    else $error("body offset not after header");

  a_word_valid: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    asm_done |=> o_word_vld && o_word == $past(asm_word[53:0]))
    else $error("program word not taken from low 54 bits");

  a_lsb_order: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (take_prog && biw == 3'h6) |=> asm_done && asm_word[55:48] == $past(i_byte)
      && asm_word[7:0] == first_byte)
    else $error("program byte order wrong");

  a_term_stop: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state == ST_TERM && take && term_idx == TERM_LAST_IDX) |=> (state == ST_STOP)[*3])
    else $error("parser did not stop after termination block");

  a_term_zero: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state == ST_TERM && take && term_idx < TERM_ID_LO_IDX && i_byte != ZERO_BYTE)
      |=> term_bad)
    else $error("nonzero termination lead byte missed");

  a_term_id: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state == ST_TERM && take && term_idx == TERM_ID_IDX && i_byte != TERM_ID_BYTE)
      |=> term_bad)
    else $error("termination id byte mismatch missed");

  a_term_tail: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state == ST_TERM && take && term_idx > TERM_ID_IDX && i_byte != ZERO_BYTE)
      |=> term_bad)
    else $error("nonzero termination tail byte missed");

  a_sum_accum: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (take && (state == ST_WORDS || state == ST_PAD))
      |=> sum == $past(sum) + {8'h00, $past(i_byte)})
    else $error("running sum not accumulated");

  a_csum_cmp: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (take && state == ST_CSUM_LO) |=> o_blk_done
      && o_blk_fail == (({$past(csum_hi), $past(i_byte)} != $past(sum)) || $past(pad_bad)))
    else $error("checksum verdict wrong");

endmodule

// ### rtl/dpl_pkg.sv
package dpl_pkg;

  // ---------------------------------------------------------------
  // Image layout
  // ---------------------------------------------------------------
  localparam int unsigned BYTE_W          = 8;
  localparam int unsigned OFS_W           = 16;
  localparam int unsigned SUM_W           = 16;
  localparam int unsigned CNT_W           = 16;
  localparam logic [15:0] HDR_BYTES       = 16'h000c;
  localparam logic [2:0]  PROG_WORD_BYTES = 3'h7;
  localparam logic [2:0]  DATA_WORD_BYTES = 3'h6;
  localparam int unsigned PROG_ASM_W      = 56;
  localparam int unsigned PROG_VALID_W    = 54;
  localparam logic [2:0]  PROG_PAD_BYTES  = 3'h5;
  localparam logic [2:0]  DATA_PAD_BYTES  = 3'h4;
  localparam logic [7:0]  ZERO_BYTE       = 8'h00;

  // ---------------------------------------------------------------
  // Termination block
  // ---------------------------------------------------------------
  localparam logic [4:0]  TERM_LAST_IDX   = 5'h13;
  localparam logic [4:0]  TERM_ID_LO_IDX  = 5'h02;
  localparam logic [4:0]  TERM_ID_IDX     = 5'h03;
  localparam logic [7:0]  TERM_ID_BYTE    = 8'h1f;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_NONE = 2'h0,
    KIND_DATA = 2'h1,
    KIND_PROG = 2'h2,
    KIND_TERM = 2'h3
  } dpl_kind_t;

  typedef enum logic [6:0] {
    ST_IDLE    = 7'b0000001,
    ST_WORDS   = 7'b0000010,
    ST_PAD     = 7'b0000100,
    ST_CSUM_HI = 7'b0001000,
    ST_CSUM_LO = 7'b0010000,
    ST_TERM    = 7'b0100000,
    ST_STOP    = 7'b1000000
  } dpl_state_t;

endpackage

// ### rtl/dpl_word_asm.sv
`timescale 1ns/10ps
module dpl_word_asm #(
  parameter int unsigned NBYTES = 7
) (
  input  wire logic                  i_ref_clk, // Core clock
  input  wire logic                  i_srst,    // Sync reset, high
  input  wire logic                  i_clr,     // Restart word
  input  wire logic                  i_load,    // Byte strobe
  input  wire logic [7:0]            i_byte,    // Image byte
  output logic      [NBYTES*8-1:0]   o_word,    // Assembled word
  output logic                       o_done     // Word complete pulse
);

  logic [2:0] cnt;

  // ---------------------------------------------------------------
  // Low byte first: each byte enters at the top and shifts down
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_word <= '0;
    end else if (i_load) begin
      o_word <= {i_byte, o_word[NBYTES*8-1:8]};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst || i_clr) begin
      cnt    <= 3'h0;
      o_done <= 1'b0;
    end else if (i_load) begin
      o_done <= (cnt == 3'(NBYTES - 1));
      cnt    <= (cnt == 3'(NBYTES - 1)) ? 3'h0 : cnt + 3'h1;
    end else begin
      o_done <= 1'b0;
    end
  end

endmodule

// ### verif/dpl_eeprom_model.sv
`timescale 1ns/10ps
module dpl_eeprom_model (
  input  wire logic       i_ref_clk, // Core clock
  output logic            o_byte_vld, // Byte strobe
  output logic [7:0]      o_byte      // Image byte
);
  logic [7:0] mem [0:255];
  logic [7:0] last;

  initial begin
    o_byte_vld = 1'b0;
    o_byte     = 8'h00;
    last       = 8'h00;
  end

  // ---------------------------------------------------------------
  // Serve image bytes in stored order, optionally one gap per byte
  // ---------------------------------------------------------------
  task automatic send(input int n, input bit slow);
    for (int i = 0; i < n; i++) begin
      if (slow) begin
        @(negedge i_ref_clk);
        o_byte_vld = 1'b0;
        o_byte     = ~last; // Released bus shows no stale byte
      end
      @(negedge i_ref_clk);
      o_byte_vld = 1'b1;
      o_byte     = mem[i];
      last       = mem[i];
    end
    @(negedge i_ref_clk);
    o_byte_vld = 1'b0;
    o_byte     = ~last;
  endtask
endmodule

// ### verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  import dpl_pkg::*;

  logic        i_ref_clk = 1'b0;
  logic        i_srst    = 1'b1;
  logic        i_blk_start = 1'b0;
  dpl_kind_t   i_blk_kind  = KIND_NONE;
  logic [15:0] i_word_cnt  = 16'h0000;
  logic [15:0] i_hdr_sum   = 16'h0000;
  logic        i_byte_vld, o_busy, o_word_vld, o_blk_done, o_blk_fail;
  logic [7:0]  i_byte;
  logic [53:0] o_word;
  logic [15:0] o_word_ofs;
  logic        o_term_done, o_term_err;
  int          mismatches  = 0;
  int          check_count = 0;
  int          done_seen   = 0;
  logic [31:0] seed = 32'hf8ba9a86;
  logic [53:0] exp_word [$];
  logic [15:0] exp_ofs  [$];
  logic        exp_fail [$];

  always #2 i_ref_clk = ~i_ref_clk;

  dpl_eeprom_model i_dpl_eeprom_model (.i_ref_clk(i_ref_clk), .o_byte_vld(i_byte_vld),
                                       .o_byte(i_byte));
  dpl_parser i_dpl_parser (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_blk_start(i_blk_start),
    .i_blk_kind(i_blk_kind), .i_word_cnt(i_word_cnt), .i_hdr_sum(i_hdr_sum),
    .i_byte_vld(i_byte_vld), .i_byte(i_byte), .o_busy(o_busy), .o_word_vld(o_word_vld),
    .o_word(o_word), .o_word_ofs(o_word_ofs), .o_blk_done(o_blk_done),
    .o_blk_fail(o_blk_fail), .o_term_done(o_term_done), .o_term_err(o_term_err));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic bad(input string msg);
    mismatches++;
    $display("ERROR %0t %s", $time, msg);
  endtask

  task automatic cmp_word(input logic [53:0] got, input logic [53:0] exp);
    check_count++;
    if (got !== exp) bad($sformatf("word %h expected %h", got, exp));
  endtask

  task automatic cmp_ofs(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) bad($sformatf("offset %h expected %h", got, exp));
  endtask

  task automatic cmp_flag(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) bad($sformatf("%s is %b expected %b", what, got, exp));
  endtask

  task automatic close_out();
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic do_reset();
    i_srst = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    i_srst = 1'b0;
  endtask

  task automatic start(input dpl_kind_t kind, input logic [15:0] cnt, input logic [15:0] hs);
    @(negedge i_ref_clk);
    i_blk_start = 1'b1;
    i_blk_kind  = kind;
    i_word_cnt  = cnt;
    i_hdr_sum   = hs;
    @(negedge i_ref_clk);
    i_blk_start = 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Result monitor
  // ---------------------------------------------------------------
  always @(negedge i_ref_clk) begin
    if (!i_srst && o_word_vld) begin
      if (exp_word.size() == 0) begin
        bad("unexpected program word");
      end else begin
        cmp_word(o_word, exp_word.pop_front());
        cmp_ofs(o_word_ofs, exp_ofs.pop_front());
      end
    end
    if (!i_srst && o_blk_done) begin
      done_seen++;
      if (exp_fail.size() == 0) bad("unexpected block done");
      else cmp_flag(o_blk_fail, exp_fail.pop_front(), "block fail");
    end
  end

  // ---------------------------------------------------------------
  // Data or program block with checksum trailer
  // ---------------------------------------------------------------
  task automatic run_blk(input dpl_kind_t kind, input int z, input bit bsum, input bit bpad,
                         input bit slow);
    int          w;
    int          p;
    int          n;
    int          seen;
    logic [15:0] sum;
    logic [15:0] hs;
    logic [55:0] wd;
    logic [7:0]  v;
    w = (kind == KIND_PROG) ? 7 : 6;
    p = (kind == KIND_PROG) ? 5 : 4;
    hs = 16'(rnd());
    sum = hs;
    n = 0;
    for (int k = 0; k < z; k++) begin
      wd = 56'({rnd(), rnd()});
      for (int b = 0; b < w; b++) begin
        i_dpl_eeprom_model.mem[n] = wd[8*b +: 8];
        sum = sum + 16'(wd[8*b +: 8]);
        n++;
      end
      if (kind == KIND_PROG) begin
        exp_word.push_back(wd[53:0]);
        exp_ofs.push_back(16'(12 + 7*k));
      end
    end
    for (int j = 0; j < p; j++) begin
      v = (bpad && j == p-1) ? 8'h01 : 8'h00;
      i_dpl_eeprom_model.mem[n] = v;
      sum = sum + 16'(v);
      n++;
    end
    if (bsum) sum = sum ^ 16'h0100;
    i_dpl_eeprom_model.mem[n]   = sum[15:8];
    i_dpl_eeprom_model.mem[n+1] = sum[7:0];
    exp_fail.push_back(bsum | bpad);
    seen = done_seen;
    start(kind, 16'(z), hs);
    cmp_flag(o_busy, 1'b1, "busy in block");
    i_dpl_eeprom_model.send(n + 2, slow);
    for (int t = 0; t < 20 && done_seen == seen; t++) @(negedge i_ref_clk);
    if (done_seen == seen) begin
      bad("block done timeout");
      close_out();
    end
    cmp_flag(1'(exp_word.size() == 0), 1'b1, "all words seen");
    @(negedge i_ref_clk);
    cmp_flag(o_busy, 1'b0, "busy after block");
  endtask

  // ---------------------------------------------------------------
  // Termination block, optionally with one wrong byte
  // ---------------------------------------------------------------
  task automatic run_term(input int bidx, input logic [7:0] bval);
    int t;
    for (int i = 0; i < 20; i++) i_dpl_eeprom_model.mem[i] = 8'h00;
    i_dpl_eeprom_model.mem[3] = 8'h1f;
    if (bidx >= 0) i_dpl_eeprom_model.mem[bidx] = bval;
    start(KIND_TERM, 16'h0000, 16'h0000);
    i_dpl_eeprom_model.send(20, bidx[0]);
    for (t = 0; t < 20 && o_term_done !== 1'b1; t++) @(negedge i_ref_clk);
    if (o_term_done !== 1'b1) begin
      bad("termination timeout");
      close_out();
    end
    cmp_flag(o_term_err, 1'(bidx >= 0), "termination error");
  endtask

  initial begin
    do_reset();
    start(KIND_NONE, 16'h0001, 16'h0000);
    cmp_flag(o_busy, 1'b0, "busy after ignored kind");
    run_blk(KIND_PROG, 3, 1'b0, 1'b0, 1'b0);
    run_blk(KIND_PROG, 1, 1'b0, 1'b0, 1'b1);
    run_blk(KIND_PROG, 2, 1'b1, 1'b0, 1'b0);
    run_blk(KIND_PROG, 1, 1'b0, 1'b1, 1'b0);
    run_blk(KIND_PROG, 0, 1'b0, 1'b0, 1'b0);
    run_blk(KIND_DATA, 2, 1'b0, 1'b0, 1'b1);
    run_blk(KIND_DATA, 1, 1'b1, 1'b0, 1'b0);
    run_blk(KIND_DATA, 1, 1'b0, 1'b1, 1'b0);
    for (int r = 0; r < 6; r++) begin
      run_blk(KIND_PROG, 1 + int'(rnd() & 32'h3), 1'b0, 1'b0, 1'(rnd()));
    end
    run_term(-1, 8'h00);
    start(KIND_PROG, 16'h0001, 16'h0000);
    i_dpl_eeprom_model.send(14, 1'b0);
    cmp_flag(o_busy, 1'b0, "busy after termination");
    cmp_flag(o_term_done, 1'b1, "termination held");
    for (int k = 0; k < 6; k++) begin
      do_reset();
      cmp_flag(o_term_done, 1'b0, "termination after reset");
      run_term((k < 4) ? k : ((k == 4) ? 4 : 19), (k == 3) ? 8'h1e : 8'h20);
    end
    close_out();
  end
endmodule
